// [timer_capture_regs.svh]
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIMER_CAPTURE_REGS_SVH
`define TIMER_CAPTURE_REGS_SVH

`define ADDR_COUNT_CTRL     8'h00
`define ADDR_COUNT_LOW      8'h04
`define ADDR_COUNT_HIGH     8'h08
`define ADDR_CAPTURE_LOW    8'h0c
`define ADDR_CAPTURE_HIGH   8'h10
`define ADDR_CAPTURE_CTRL   8'h14
`define ADDR_INT_FLAGS      8'h18
`define ADDR_INT_ENABLE     8'h1c

`define CTRL_ON_BIT         0
`define CTRL_GATE_BIT       1
`define CTRL_ASYNC_BIT      2
`define CTRL_OSC_BIT        3
`define CTRL_PS_LO          4
`define CTRL_PS_HI          5
`define CTRL_SRC_LO         6
`define CTRL_SRC_HI         7

`define FLAG_OVF_BIT        0
`define FLAG_CAP_BIT        2
`define FLAG_MASK           8'h05

`define RST_COUNT_CTRL      8'h00
`define RST_COUNT           16'h0000
`define RST_CAPTURE_CTRL    4'h0
`define RST_INT_FLAGS       8'h00
`define RST_INT_ENABLE      8'h00

`define INSTR_DIV_LAST      2'h3
`define CAP_EVERY4_LAST     2'h3
`define CAP_EVERY16_LAST    4'hf

`endif

// [timer_capture_pkg.sv]
// Types shared by the timer and capture modules.
package timer_capture_pkg;

    typedef enum logic [1:0] {
        SRC_INSTR    = 2'h0,
        SRC_SYSTEM   = 2'h1,
        SRC_EXTERNAL = 2'h2,
        SRC_CAPSENSE = 2'h3
    } count_src_t;

    typedef enum logic [3:0] {
        CAP_OFF     = 4'h0,
        CAP_FALL    = 4'h4,
        CAP_RISE    = 4'h5,
        CAP_RISE4   = 4'h6,
        CAP_RISE16  = 4'h7
    } cap_mode_t;

endpackage : timer_capture_pkg

// [timer_link_if.sv]
// Signals between the timer core, its prescaler and its capture unit.
`timescale 1ns/1ps
interface timer_link_if;
    logic        tick;
    logic [1:0]  ps_sel;
    logic        ps_clear;
    logic        advance;
    logic [15:0] count_value;
    logic [3:0]  cap_mode;
    logic        event_level;
    logic        capture_pulse;
    logic [15:0] capture_value;

    modport presc (input tick, input ps_sel, input ps_clear,
                   output advance);
    modport capt  (input count_value, input cap_mode, input event_level,
                   output capture_pulse, output capture_value);
    modport core  (output tick, output ps_sel, output ps_clear,
                   input advance, output count_value, output cap_mode,
                   output event_level, input capture_pulse,
                   input capture_value);
endinterface : timer_link_if

// [count_prescaler.sv]
// Divide-by-1/2/4/8 prescaler in front of the 16-bit counter.
`timescale 1ns/1ps
module count_prescaler (
    // Clock and reset
    input wire logic   core_clk,
    input wire logic   srst,
    // Link to the timer core
    timer_link_if.presc link
);
    logic [2:0] ps_cnt_r;
    logic [2:0] ps_mask;
    logic       ps_last;

    always_comb begin
        case (link.ps_sel)
            2'h0:    ps_mask = 3'h0;
            2'h1:    ps_mask = 3'h1;
            2'h2:    ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end

    assign ps_last = ((ps_cnt_r & ps_mask) == ps_mask);

    assign link.advance = link.tick && ps_last;

    always_ff @(posedge core_clk) begin
        if (srst || link.ps_clear) begin
            ps_cnt_r <= 3'h0;
        end else if (link.tick) begin
            ps_cnt_r <= ps_last ? 3'h0 : ps_cnt_r + 3'h1;
        end
    end
endmodule : count_prescaler

// [capture_unit.sv]
// Edge capture of the running count with its own event prescaler.
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module capture_unit (
    // Clock and reset
    input wire logic  core_clk,
    input wire logic  srst,
    // Link to the timer core
    timer_link_if.capt link
);
    logic        level_prev_r;
    logic [3:0]  ev_cnt_r;
    logic [15:0] capture_value_r;
    logic        in_capture;
    logic        rise;
    logic        fall;
    logic        hit;

    assign in_capture = (link.cap_mode[3:2] == 2'h1);
    assign rise       = link.event_level && !level_prev_r;
    assign fall       = !link.event_level && level_prev_r;

    always_comb begin
        case (link.cap_mode)
            timer_capture_pkg::CAP_FALL:   hit = fall;
            timer_capture_pkg::CAP_RISE:   hit = rise;
            timer_capture_pkg::CAP_RISE4:
                hit = rise && (ev_cnt_r[1:0] == `CAP_EVERY4_LAST);
            timer_capture_pkg::CAP_RISE16:
                hit = rise && (ev_cnt_r == `CAP_EVERY16_LAST);
            default:                       hit = 1'b0;
        endcase
    end

    assign link.capture_pulse = hit;
    assign link.capture_value = capture_value_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            level_prev_r <= 1'b0;
        end else begin
            level_prev_r <= link.event_level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !in_capture) begin
            ev_cnt_r <= 4'h0;
        end else if (rise) begin
            ev_cnt_r <= hit ? 4'h0 : ev_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            capture_value_r <= `RST_COUNT;
        end else if (hit) begin
            capture_value_r <= link.count_value;
        end
    end
endmodule : capture_unit

// [timer_capture_top.sv]
// 16-bit timer with selectable source, prescaler and capture, on APB.
//
// Contract
// - Source field and oscillator enable pick system, instruction, pin, osc.
// - Internal source advances counter once per prescaled clock period.
// - External source counts rising edges, synchronised or asynchronous.
// - Counter mode needs a falling edge before its first counting edge.
// - Prescaler divides counter clock by 1, 2, 4 or 8.
// - Prescale count is hidden and cleared by any counter byte write.
// - Low-frequency oscillator enabled by its bit and runs in sleep.
// - Sync-disable bit bypasses synchronisation; counting goes asynchronous.
// - Asynchronous external counting runs in sleep; overflow can wake.
// - Sync mode changes may drop or add one increment.
// - Counter byte reads are valid under asynchronous external clock.
// - Capture latches count on falling, rising, 4th or 16th rising.
// - Each capture sets the capture flag until software clears it.
// - A new capture overwrites an unread previous capture.
// - Capture watches the pad level even when driven as output.
// - Capture prescaler cleared when off, not capturing, or reset.
// - Capture prescale change keeps the count; may fire falsely.
// - On instruction clock the counter holds in sleep, then resumes.
// - 16-bit counter; a byte write updates the count at once.
// - On bit off stops; on without gate runs; with gate, gated.
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module timer_capture_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock source pins
    input  wire logic        ext_count_clock_pin,
    input  wire logic        capsense_osc_in,
    input  wire logic        crystal_in_pin,
    output logic             crystal_out_pin,
    // Gate, capture and power state
    input  wire logic        count_gate_pin,
    input  wire logic        capture_event_pin,
    input  wire logic        sleep_mode,
    output logic             wake_irq
);
    timer_link_if link ();

    logic [7:0]  ctrl_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [3:0]  cap_ctrl_r;
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  enable_r;
    logic [1:0]  instr_div_r;
    logic        armed_r;
    logic        gate_q_r;
    logic        event_q_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        crystal_out_r;
    logic        wake_irq_r;

    logic        apb_setup;
    logic        apb_wr;
    logic        addr_ok;
    logic        wr_low;
    logic        wr_high;
    logic        count_on;
    logic        async_mode;
    logic        osc_en;
    logic        src_external;
    logic        count_enable;
    logic        instr_tick;
    logic        tick_src;
    logic        overflow;
    logic [2:0]  clk_in;
    logic [2:0]  sync_rise;
    logic [2:0]  sync_fall;
    logic [2:0]  raw_rise;
    logic [2:0]  raw_fall;
    logic [1:0]  ext_idx;
    logic        ext_rise;
    logic        ext_fall;
    logic [7:0]  rd_data;
    timer_capture_pkg::count_src_t src;

    assign src = timer_capture_pkg::count_src_t'(
                     ctrl_r[`CTRL_SRC_HI:`CTRL_SRC_LO]);
    assign count_on   = ctrl_r[`CTRL_ON_BIT];
    assign async_mode = ctrl_r[`CTRL_ASYNC_BIT];
    assign osc_en     = ctrl_r[`CTRL_OSC_BIT];

    // APB: one wait state, answer raised from a flop.
    assign apb_setup = psel && penable && !pready_r;
    assign apb_wr    = psel && penable && pready_r && pwrite && !pslverr_r;
    assign wr_low    = apb_wr && (paddr == `ADDR_COUNT_LOW);
    assign wr_high   = apb_wr && (paddr == `ADDR_COUNT_HIGH);

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            `ADDR_COUNT_CTRL:   rd_data = ctrl_r;
            `ADDR_COUNT_LOW:    rd_data = count_r[7:0];
            `ADDR_COUNT_HIGH:   rd_data = count_r[15:8];
            `ADDR_CAPTURE_LOW:  rd_data = link.capture_value[7:0];
            `ADDR_CAPTURE_HIGH: rd_data = link.capture_value[15:8];
            `ADDR_CAPTURE_CTRL: rd_data = {4'h0, cap_ctrl_r};
            `ADDR_INT_FLAGS:    rd_data = flags_r;
            `ADDR_INT_ENABLE:   rd_data = enable_r;
            default: begin
                rd_data = 8'h00;
                addr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup && !addr_ok;
            if (apb_setup && !pwrite) begin
                prdata_r <= {24'h00_0000, rd_data};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_r     <= `RST_COUNT_CTRL;
            cap_ctrl_r <= `RST_CAPTURE_CTRL;
            enable_r   <= `RST_INT_ENABLE;
        end else if (apb_wr) begin
            case (paddr)
                `ADDR_COUNT_CTRL:   ctrl_r     <= pwdata[7:0];
                `ADDR_CAPTURE_CTRL: cap_ctrl_r <= pwdata[3:0];
                `ADDR_INT_ENABLE:   enable_r   <= pwdata[7:0] & `FLAG_MASK;
                default:            ctrl_r     <= ctrl_r;
            endcase
        end
    end

    // Pins arrive asynchronous; each source has a settled and a raw path.
    assign clk_in = {crystal_in_pin, capsense_osc_in, ext_count_clock_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_src
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic raw_r;
            logic raw_prev_r;
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    s1_r       <= 1'b0;
                    s2_r       <= 1'b0;
                    s3_r       <= 1'b0;
                    raw_r      <= 1'b0;
                    raw_prev_r <= 1'b0;
                end else begin
                    s1_r       <= clk_in[gi];
                    s2_r       <= s1_r;
                    s3_r       <= s2_r;
                    raw_r      <= clk_in[gi];
                    raw_prev_r <= raw_r;
                end
            end
            assign sync_rise[gi] = s2_r && !s3_r;
            assign sync_fall[gi] = !s2_r && s3_r;
            assign raw_rise[gi]  = raw_r && !raw_prev_r;
            assign raw_fall[gi]  = !raw_r && raw_prev_r;
        end
    endgenerate

    always_comb begin
        if (src == timer_capture_pkg::SRC_CAPSENSE) begin
            ext_idx = 2'h1;
        end else if (osc_en) begin
            ext_idx = 2'h2;
        end else begin
            ext_idx = 2'h0;
        end
    end

    assign ext_rise = async_mode ? raw_rise[ext_idx] : sync_rise[ext_idx];
    assign ext_fall = async_mode ? raw_fall[ext_idx] : sync_fall[ext_idx];

    assign src_external = ctrl_r[`CTRL_SRC_HI];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            crystal_out_r <= 1'b0;
        end else begin
            crystal_out_r <= osc_en && !crystal_in_pin;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            instr_div_r <= 2'h0;
            gate_q_r    <= 1'b0;
            event_q_r   <= 1'b0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
            gate_q_r    <= count_gate_pin;
            event_q_r   <= capture_event_pin;
        end
    end
    assign instr_tick = (instr_div_r == `INSTR_DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (srst || !count_on || wr_low || wr_high) begin
            armed_r <= 1'b0;
        end else if (ext_fall) begin
            armed_r <= 1'b1;
        end
    end

    assign count_enable = count_on && (!ctrl_r[`CTRL_GATE_BIT] || gate_q_r);

    always_comb begin
        case (src)
            timer_capture_pkg::SRC_SYSTEM:
                tick_src = !sleep_mode;
            timer_capture_pkg::SRC_INSTR:
                tick_src = instr_tick && !sleep_mode;
            default:
                tick_src = src_external && ext_rise && armed_r &&
                           (async_mode || !sleep_mode);
        endcase
    end

    assign link.tick     = count_enable && tick_src;
    assign link.ps_sel   = ctrl_r[`CTRL_PS_HI:`CTRL_PS_LO];
    assign link.ps_clear = wr_low || wr_high;

    // a write beats a coincident increment
    always_comb begin
        count_nxt = count_r;
        if (wr_low || wr_high) begin
            if (wr_low) begin
                count_nxt[7:0] = pwdata[7:0];
            end
            if (wr_high) begin
                count_nxt[15:8] = pwdata[7:0];
            end
        end else if (link.advance) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_r <= `RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign overflow = link.advance && !wr_low && !wr_high &&
                      (count_r == 16'hffff);

    assign link.count_value = count_r;
    assign link.cap_mode    = cap_ctrl_r;
    assign link.event_level = event_q_r;

    // overflow and capture set flags
    // Hardware set wins over a software clear in the same cycle.
    always_comb begin
        flags_nxt = flags_r;
        if (apb_wr && (paddr == `ADDR_INT_FLAGS)) begin
            flags_nxt = pwdata[7:0] & `FLAG_MASK;
        end
        if (overflow) begin
            flags_nxt[`FLAG_OVF_BIT] = 1'b1;
        end
        if (link.capture_pulse) begin
            flags_nxt[`FLAG_CAP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flags_r <= `RST_INT_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wake_irq_r <= 1'b0;
        end else begin
            wake_irq_r <= |(flags_r & enable_r);
        end
    end

    count_prescaler u_prescaler (
        .core_clk (core_clk),
        .srst     (srst),
        .link     (link.presc)
    );

    capture_unit u_capture (
        .core_clk (core_clk),
        .srst     (srst),
        .link     (link.capt)
    );

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign crystal_out_pin = crystal_out_r;
    assign wake_irq        = wake_irq_r;
endmodule : timer_capture_top

// [timer_capture_chk.sv]
// Assertions on the timer's bus and pins.
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module timer_capture_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        ext_count_clock_pin,
    input wire logic        capsense_osc_in,
    input wire logic        crystal_in_pin,
    input wire logic        crystal_out_pin,
    input wire logic        count_gate_pin,
    input wire logic        capture_event_pin,
    input wire logic        sleep_mode,
    input wire logic        wake_irq
);
    logic [7:0] ctrl_r;
    logic [7:0] en_r;
    wire logic  wr_ok    = psel && penable && pready && pwrite;
    wire logic  bad_addr = paddr > `ADDR_INT_ENABLE || paddr[1:0] != 2'h0;

    // Shadows follow observed writes, since the register bodies are hidden.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_r <= 8'h00;
            en_r   <= 8'h00;
        end else if (wr_ok && paddr == `ADDR_COUNT_CTRL) begin
            ctrl_r <= pwdata[7:0];
        end else if (wr_ok && paddr == `ADDR_INT_ENABLE) begin
            en_r <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    ready_timing_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("late pready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("long pready");
    ready_in_access_a: assert property (
        pready |-> psel && penable && $past(penable))
        else $error("stray pready");
    err_unmapped_a: assert property (pready && bad_addr |-> pslverr)
        else $error("no pslverr");
    err_mapped_a: assert property (pslverr |-> pready && bad_addr)
        else $error("false pslverr");
    rdata_upper_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0 &&
        (!pslverr || prdata[7:0] == 8'h00))
        else $error("prdata upper bits set");
    xtal_off_a: assert property (
        !ctrl_r[3] && !$past(ctrl_r[3]) |-> !crystal_out_pin)
        else $error("xtal out while off");
    xtal_on_a: assert property (
        ctrl_r[3] && $past(ctrl_r[3]) |->
        crystal_out_pin == !$past(crystal_in_pin))
        else $error("xtal out not inverted");
    wake_masked_a: assert property (
        (en_r & 8'h05) == 8'h00 && ($past(en_r) & 8'h05) == 8'h00
        |-> !wake_irq)
        else $error("wake with enables clear");
endmodule : timer_capture_chk

bind timer_capture_top timer_capture_chk chk_i (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(ext_count_clock_pin),
    .capsense_osc_in(capsense_osc_in), .crystal_in_pin(crystal_in_pin),
    .crystal_out_pin(crystal_out_pin), .count_gate_pin(count_gate_pin),
    .capture_event_pin(capture_event_pin), .sleep_mode(sleep_mode),
    .wake_irq(wake_irq)
);

// [pin_source.sv]
// Count clock sources and capture pad outside the block.
`timescale 1ns/1ps
module pin_source (
    // Clock
    input wire logic core_clk,
    // Pins towards the block
    output logic     ext_clk,
    output logic     osc_clk,
    output logic     xtal_clk,
    output logic     pad
);
    initial {ext_clk, osc_clk, xtal_clk, pad} = 4'h0;
    task automatic drive(input logic [1:0] sel, input logic v);
        @(posedge core_clk);
        case (sel)
            2'h0: ext_clk <= v;
            2'h1: osc_clk <= v;
            2'h2: xtal_clk <= v;
            default: pad <= v;
        endcase
        repeat (3) @(posedge core_clk);
    endtask : drive
    task automatic pulse(input logic [1:0] sel, input int n);
        repeat (n) begin
            drive(sel, 1'b1);
            drive(sel, 1'b0);
        end
    endtask : pulse
endmodule : pin_source

// [tb_top.sv]
// Self-checking bench of the timer with capture.
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module tb_top;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk;
    logic        osc_clk;
    logic        xtal_clk;
    logic        pad;
    logic        gate     = 1'b0;
    logic        sleep    = 1'b0;
    logic        wake_irq;
    int          failures = 0;
    int          n_tests  = 0;

    always #20 core_clk = ~core_clk;

    timer_capture_top dut (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_count_clock_pin(ext_clk),
        .capsense_osc_in(osc_clk), .crystal_in_pin(xtal_clk),
        .crystal_out_pin(), .count_gate_pin(gate),
        .capture_event_pin(pad), .sleep_mode(sleep), .wake_irq(wake_irq)
    );
    pin_source src (.core_clk(core_clk), .ext_clk(ext_clk),
        .osc_clk(osc_clk), .xtal_clk(xtal_clk), .pad(pad));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input logic [15:0] g);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            failures++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // Read before this edge updates it.
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic [31:0] q;
        logic        e;
        bus(1'b0, a, 8'h00, q, e);
        v = q[7:0];
    endtask : rd

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h04, v[15:8]);
    endtask : rd16

    function automatic logic [7:0] ctl(input int s, p, a, o, g, on);
        return {s[1:0], p[1:0], o[0], a[0], g[0], on[0]};
    endfunction : ctl

    task automatic zero();
        wr(`ADDR_COUNT_CTRL, 8'h00);
        wr(`ADDR_COUNT_LOW, 8'h00);
        wr(`ADDR_COUNT_HIGH, 8'h00);
    endtask : zero

    task automatic s_regs();
        logic [31:0] q;
        logic        e;
        for (int a = 0; a <= 'h1c; a += 4) begin
            bus(1'b0, a[7:0], 8'h00, q, e);
            chk("reset value", 16'h0000, q[15:0]);
        end
        bus(1'b1, 8'h24, 8'hff, q, e);
        chk("unmapped error", 16'h0001, {15'h0, e});
    endtask : s_regs

    task automatic s_rate();
        logic [15:0] v;
        int          x;
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                zero();
                wr(`ADDR_COUNT_CTRL, ctl(s, p, 0, 0, 0, 1));
                repeat (400) @(posedge core_clk);
                wr(`ADDR_COUNT_CTRL, 8'h00);
                rd16(`ADDR_COUNT_LOW, v);
                x = 404 / ((s == 0 ? 4 : 1) << p);
                chk_rng("count rate", x - 2, x + 2, v);
            end
        end
        zero();
        wr(`ADDR_COUNT_CTRL, ctl(1, 0, 0, 0, 1, 1));
        repeat (50) @(posedge core_clk);
        gate <= 1'b1;
        repeat (50) @(posedge core_clk);
        wr(`ADDR_COUNT_CTRL, 8'h00);
        rd16(`ADDR_COUNT_LOW, v);
        chk_rng("gated count", 48, 58, v);
    endtask : s_rate

    task automatic s_ext();
        logic [15:0] v;
        for (int k = 0; k < 3; k++) begin
            zero();
            wr(`ADDR_COUNT_CTRL, ctl(k == 1 ? 3 : 2, 0, 0, k == 2, 0, 0));
            wr(`ADDR_COUNT_CTRL, ctl(k == 1 ? 3 : 2, 0, 0, k == 2, 0, 1));
            src.pulse(k[1:0], 5);
            repeat (8) @(posedge core_clk);
            wr(`ADDR_COUNT_CTRL, 8'h00);
            rd16(`ADDR_COUNT_LOW, v);
            chk("external count", 16'h0004, v);
        end
    endtask : s_ext

    task automatic s_sleep();
        logic [15:0] v;
        logic [7:0]  b;
        wr(`ADDR_COUNT_CTRL, 8'h00);
        wr(`ADDR_COUNT_LOW, 8'hfe);
        wr(`ADDR_COUNT_HIGH, 8'hff);
        wr(`ADDR_INT_ENABLE, 8'h01);
        sleep <= 1'b1;
        wr(`ADDR_COUNT_CTRL, ctl(2, 0, 1, 0, 0, 1));
        src.pulse(2'h0, 5);
        repeat (8) @(posedge core_clk);
        chk("wake in sleep", 16'h0001, {15'h0, wake_irq});
        wr(`ADDR_COUNT_CTRL, 8'h00);
        rd16(`ADDR_COUNT_LOW, v);
        chk("async count", 16'h0002, v);
        zero();
        wr(`ADDR_COUNT_CTRL, 8'h01);
        repeat (200) @(posedge core_clk);
        wr(`ADDR_COUNT_CTRL, 8'h00);
        rd16(`ADDR_COUNT_LOW, v);
        chk("held in sleep", 16'h0000, v);
        sleep <= 1'b0;
        wr(`ADDR_INT_FLAGS, 8'h00);
        rd(`ADDR_INT_FLAGS, b);
        chk("flag cleared", 16'h0000, {8'h0, b});
    endtask : s_sleep

    task automatic s_cap();
        logic [15:0] v;
        logic [7:0]  b;
        logic [3:0]  m;
        int          n;
        zero();
        wr(`ADDR_CAPTURE_CTRL, 8'h05);
        wr(`ADDR_INT_FLAGS, 8'h00);
        wr(`ADDR_COUNT_LOW, 8'h34);
        wr(`ADDR_COUNT_HIGH, 8'h12);
        src.pulse(2'h3, 1);
        wr(`ADDR_COUNT_LOW, 8'h78);
        wr(`ADDR_COUNT_HIGH, 8'h56);
        src.pulse(2'h3, 1);
        rd16(`ADDR_CAPTURE_LOW, v);
        chk("capture value", 16'h5678, v);
        for (int i = 0; i < 4; i++) begin
            m = 4'h4 + 4'(i);
            n = (i == 2) ? 4 : (i == 3) ? 16 : 1;
            wr(`ADDR_CAPTURE_CTRL, 8'h00);
            wr(`ADDR_CAPTURE_CTRL, {4'h0, m});
            wr(`ADDR_INT_FLAGS, 8'h00);
            wr(`ADDR_COUNT_LOW, {4'h0, m});
            src.pulse(2'h3, n - 1);
            rd(`ADDR_INT_FLAGS, b);
            chk("early flag", 16'h0000, {8'h0, b});
            src.pulse(2'h3, 1);
            rd(`ADDR_INT_FLAGS, b);
            chk("capture flag", 16'h0004, {8'h0, b});
            rd(`ADDR_CAPTURE_LOW, b);
            chk("mode capture", {12'h0, m}, {8'h0, b});
        end
        wr(`ADDR_CAPTURE_CTRL, 8'h06);
        src.pulse(2'h3, 2);
        wr(`ADDR_CAPTURE_CTRL, 8'h00);
        wr(`ADDR_CAPTURE_CTRL, 8'h06);
        wr(`ADDR_INT_FLAGS, 8'h00);
        src.pulse(2'h3, 3);
        rd(`ADDR_INT_FLAGS, b);
        chk("prescaler cleared", 16'h0000, {8'h0, b});
    endtask : s_cap

    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        s_regs();
        s_rate();
        s_ext();
        s_sleep();
        s_cap();
        tally_and_finish();
    end

    // Runs need about 4500 cycles.
    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
